// ---- itd_checker.sv ----
/*
 Port-level checks of the input terminal function decoder.
 Assumes it is bound to itd_top and sees only its ports.
*/
`timescale 1ns/1ps
module itd_checker
	import itd_pkg::*;
(
	input wire logic clk_in, // Clock.
	input wire logic reset_in, // Reset.
	input wire logic [5:0] switch_in_n_in, // Switch pins.
	input wire logic fast_pulse_n_in, // Pulse pin.
	input wire logic keypad_reset_in, // Keypad key.
	input wire logic [3:0] addr_in, // Address.
	input wire logic [7:0] wdata_in, // Write data.
	input wire logic wr_in, // Write strobe.
	input wire logic rd_in, // Read strobe.
	input wire logic [7:0] rdata_out, // Read data.
	input wire itd_cmd_s cmd_out, // Commands.
	input wire logic fault_active_out, // Fault latched.
	input wire logic [7:0] fault_code_out, // Fault code.
	input wire logic irq_out // Interrupt.
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	logic [6:0] pins;
	logic any_closed;
	assign pins = {fast_pulse_n_in, switch_in_n_in};
	assign any_closed = pins != 7'h7F;
	////////////////////////////////////////////////////////////////////////
	sequence all_open;
		(!any_closed)[*2];
	endsequence
	sequence settled;
		($stable(pins) && !wr_in && !keypad_reset_in)[*4];
	endsequence
	////////////////////////////////////////////////////////////////////////
	fault_code_a: assert property (
		fault_code_out == (fault_active_out ? 8'h13 : 8'h00))
		else $error("fault code does not follow fault flag");
	idle_cmd_a: assert property (
		all_open |-> (cmd_out & 16'hDEFF) == 16'h0000)
		else $error("command active with all terminals open");
	hold_cmd_a: assert property (
		settled |-> $stable(cmd_out))
		else $error("commands moved without a cause");
	rdata_idle_a: assert property (
		!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside the read answer cycle");
	reset_out_a: assert property (disable iff (1'b0)
		reset_in |=> cmd_out == '0 && !fault_active_out && !irq_out)
		else $error("outputs not cleared by reset");
	fault_clear_a: assert property (
		$fell(fault_active_out) |-> $past(keypad_reset_in) ||
		$past(any_closed) || $past(reset_in))
		else $error("fault cleared without a reset request");
	irq_fall_a: assert property (
		$fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2) ||
		$past(reset_in))
		else $error("interrupt dropped without a register write");
	rsvd_read_a: assert property (
		$past(rd_in) && $past(addr_in) == 4'h7 |-> rdata_out == 8'h00)
		else $error("reserved selector read nonzero");
endmodule
bind itd_top itd_checker chk_i (.clk_in(clk_in), .reset_in(reset_in),
	.switch_in_n_in(switch_in_n_in), .fast_pulse_n_in(fast_pulse_n_in),
	.keypad_reset_in(keypad_reset_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .cmd_out(cmd_out),
	.fault_active_out(fault_active_out), .fault_code_out(fault_code_out),
	.irq_out(irq_out));

// ---- itd_contacts.sv ----
/*
 Bank of external contacts that close the terminals to the common return.
 Assumes the bench says which contacts are closed; pins have pull-ups.
*/
`timescale 1ns/1ps
module itd_contacts (
	input wire logic [6:0] closed_in, // Closed contacts, bit 6 is pulse pin.
	output logic [5:0] switch_in_n_out, // Switch pins.
	output logic fast_pulse_n_out // Fast pulse pin.
);
	// An open contact leaves the pin at its pull-up level.
	assign {fast_pulse_n_out, switch_in_n_out} = ~closed_in;
endmodule

// ---- itd_decode.sv ----
/*
 Combinational decode of terminal levels and function codes into commands.
 Assumes terminal levels are already synchronous and high while shorted.
*/
`timescale 1ns/1ps
module itd_decode
	import itd_pkg::*;
(
	input wire logic [6:0] level_in, // Terminal active levels.
	input wire logic [55:0] func_in, // Seven packed function codes.
	input wire itd_mode_s mode_in, // Mode settings.
	output itd_cmd_s cmd_out // Decoded commands.
);
	// Any terminal holding the code and asserted drives the command.
	function automatic logic any_code(input logic [6:0] lv,
			input logic [55:0] fc, input logic [7:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (fc[i*8 +: 8] == code && lv[i]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	// True when some terminal holds the code, asserted or not.
	function automatic logic has_code(input logic [55:0] fc,
			input logic [7:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (fc[i*8 +: 8] == code) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	logic run_ok;
	logic three_wire;
	logic nc_open;

	always_comb begin
		run_ok = mode_in.run_source_terminal;
		three_wire = mode_in.op_mode == 2'h2 || mode_in.op_mode == 2'h3;
		nc_open = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (func_in[i*8 +: 8] == `ITD_C_FNC && !level_in[i]) begin
				nc_open = 1'b1;
			end
		end
		cmd_out = '0;
		cmd_out.forward_run = run_ok
			&& any_code(level_in, func_in, `ITD_C_FORWARD);
		cmd_out.backward_run = run_ok
			&& any_code(level_in, func_in, `ITD_C_BACKWARD);
		cmd_out.three_wire_stop = three_wire
			&& has_code(func_in, `ITD_C_3W)
			&& !any_code(level_in, func_in, `ITD_C_3W);
		cmd_out.jog_forward = run_ok
			&& any_code(level_in, func_in, `ITD_C_JOGF);
		cmd_out.jog_backward = run_ok
			&& any_code(level_in, func_in, `ITD_C_JOGR);
		cmd_out.coast_stop = any_code(level_in, func_in, `ITD_C_COAST);
		cmd_out.fault_clear = any_code(level_in, func_in, `ITD_C_CLR);
		cmd_out.ext_fault = nc_open
			|| any_code(level_in, func_in, `ITD_C_FNO);
		cmd_out.emergency_stop = any_code(level_in, func_in,
			`ITD_C_ESTOP);
		cmd_out.freq_up = mode_in.step_source
			&& any_code(level_in, func_in, `ITD_C_UP);
		cmd_out.freq_down = mode_in.step_source
			&& any_code(level_in, func_in, `ITD_C_DOWN);
		cmd_out.step_clear = any_code(level_in, func_in, `ITD_C_STEPCLR);
		for (int b = 0; b < 4; b++) begin
			cmd_out.speed_segment[b] = any_code(level_in, func_in,
				8'(`ITD_C_SPD0 + b));
		end
	end
endmodule

// ---- itd_func_reg.sv ----
/*
 One function selector register with its mode-dependent reset default.
 Assumes a synchronous active-high reset and a single-cycle write strobe.
*/
`timescale 1ns/1ps
module itd_func_reg
	import itd_pkg::*;
(
	input wire logic clk_in, // System clock.
	input wire logic reset_in, // Synchronous reset.
	input wire logic [7:0] default_in, // Value taken at reset.
	input wire logic write_in, // Write strobe for this selector.
	input wire logic [7:0] data_in, // Write data.
	output logic [7:0] func_out // Current function code.
);
	logic [7:0] func_q;
	logic [7:0] next_func;

	// Codes above the top of range are refused and the old code stays.
	always_comb begin
		next_func = func_q;
		if (write_in && data_in <= `ITD_FUNC_MAX) begin
			next_func = data_in;
		end
	end

	// A constant-only async reset is not used; the default is a clocked load.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			func_q <= default_in;
		end else begin
			func_q <= next_func;
		end
	end

	assign func_out = func_q;
endmodule

// ---- itd_params.svh ----
/*
 Constants of the input terminal function decoder: register offsets, field
 positions, reset values and the function codes.
 Assumes inclusion by the package and the design modules.
*/
// Operation
// - Each switch input and the fast pulse input has a function selector taking codes 0 to 65, and code 0 does nothing.
// - With control mode 2 or 3, switch inputs 1, 3, 4, 5 and 6 reset to functions 58, 60, 61, 62 and 63.
// - With the tension parameter nonzero, switch input 2 resets to function 59, otherwise to 2.
// - The fast pulse selector resets to 45 and switch inputs 1 to 6 reset to 1, 2, 4, 7, 8 and 0.
// - Code 1 commands forward running while asserted, only when the run source is 1.
// - Code 2 commands reverse running while asserted, only when the run source is 1.
// - Code 3 is the stop/enable contact of three-wire operation modes 2 and 3.
// - Codes 4 and 5 command forward and reverse jog while asserted, only when the run source is 1.
// - Code 6 triggers a coast-to-stop shutdown.
// - Code 7 clears a latched fault like the keypad reset key, on any command channel.
// - Codes 8 (make) and 9 (break) raise the external equipment fault, shown as code 19.
// - Code 10 starts an emergency stop using the emergency deceleration time.
// - Codes 12 and 13 raise or lower the frequency while asserted, only with the step-adjust source.
// - Code 14 clears the accumulated step-adjust increment.
// - Codes 15 to 18 are preset bits of weight 1, 2, 4 and 8 and the segment is their sum.
`ifndef ITD_PARAMS_SVH
`define ITD_PARAMS_SVH

`define ITD_ADDR_FUNC0 4'h0
`define ITD_ADDR_FUNC7 4'h7
`define ITD_ADDR_MODE 4'h8
`define ITD_ADDR_STATUS 4'h9
`define ITD_ADDR_MASK 4'hA
`define ITD_ADDR_CMD 4'hB
`define ITD_ADDR_PINS 4'hC

`define ITD_MODE_CTRL_LSB 0
`define ITD_MODE_RUNSRC_BIT 2
`define ITD_MODE_STEP_BIT 3
`define ITD_MODE_TENSION_BIT 4
`define ITD_MODE_OPMODE_LSB 5

`define ITD_FUNC_MAX 8'h41
`define ITD_RST_F1 8'h01
`define ITD_RST_F2 8'h02
`define ITD_RST_F3 8'h04
`define ITD_RST_F4 8'h07
`define ITD_RST_F5 8'h08
`define ITD_RST_F6 8'h00
`define ITD_RST_FP 8'h2D
`define ITD_ALT_F1 8'h3A
`define ITD_ALT_F2 8'h3B
`define ITD_ALT_F3 8'h3C
`define ITD_ALT_F4 8'h3D
`define ITD_ALT_F5 8'h3E
`define ITD_ALT_F6 8'h3F
`define ITD_FAULT_CODE 8'h13

`define ITD_C_FORWARD 8'h01
`define ITD_C_BACKWARD 8'h02
`define ITD_C_3W 8'h03
`define ITD_C_JOGF 8'h04
`define ITD_C_JOGR 8'h05
`define ITD_C_COAST 8'h06
`define ITD_C_CLR 8'h07
`define ITD_C_FNO 8'h08
`define ITD_C_FNC 8'h09
`define ITD_C_ESTOP 8'h0A
`define ITD_C_UP 8'h0C
`define ITD_C_DOWN 8'h0D
`define ITD_C_STEPCLR 8'h0E
`define ITD_C_SPD0 8'h0F

`endif

// ---- itd_pkg.sv ----
/*
 Types of the input terminal function decoder.
 Assumes the constants header is available on the include path.
*/
package itd_pkg;
	`include "itd_params.svh"

	typedef struct packed {
		logic forward_run;
		logic backward_run;
		logic three_wire_stop;
		logic jog_forward;
		logic jog_backward;
		logic coast_stop;
		logic fault_clear;
		logic ext_fault;
		logic emergency_stop;
		logic freq_up;
		logic freq_down;
		logic step_clear;
		logic [3:0] speed_segment;
	} itd_cmd_s;

	// Field order follows the mode register bit positions, msb first.
	typedef struct packed {
		logic [1:0] op_mode;
		logic tension_nonzero;
		logic step_source;
		logic run_source_terminal;
		logic [1:0] control_mode;
	} itd_mode_s;
endpackage

// ---- itd_top.sv ----
/*
 Input terminal function decoder: seven selector registers, command decode,
 fault latch, event status with mask and interrupt, and a register port.
 Assumes synchronous terminal inputs that are low while shorted to the
 common return, and a register master with one-cycle strobes.
*/
`timescale 1ns/1ps
module itd_top
	import itd_pkg::*;
(
	input wire logic clk_in, // 200 MHz system clock.
	input wire logic reset_in, // Synchronous reset, active high.
	input wire logic [5:0] switch_in_n_in, // Switch inputs, low when shorted.
	input wire logic fast_pulse_n_in, // Fast pulse input, low when shorted.
	input wire logic keypad_reset_in, // Keypad stop/reset key pulse.
	input wire logic [3:0] addr_in, // Register address.
	input wire logic [7:0] wdata_in, // Register write data.
	input wire logic wr_in, // Write strobe.
	input wire logic rd_in, // Read strobe.
	output logic [7:0] rdata_out, // Read data, cycle after read.
	output itd_cmd_s cmd_out, // Registered commands.
	output logic fault_active_out, // External fault latched.
	output logic [7:0] fault_code_out, // Shown fault code, zero if none.
	output logic irq_out // Interrupt, level.
);
	////////////////////////////////////////////////////////////////////////
	// Mode register, written by software, steering defaults and gating.

	itd_mode_s mode_q;
	itd_mode_s next_mode;
	logic alt_ctrl;

	always_comb begin
		next_mode = mode_q;
		if (wr_in && addr_in == `ITD_ADDR_MODE) begin
			next_mode = itd_mode_s'(wdata_in[6:0]);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mode_q <= '0;
		end else begin
			mode_q <= next_mode;
		end
	end

	// Mode is cleared by reset too; selectors take defaults from the mode held at the reset edge.
	assign alt_ctrl = mode_q.control_mode == 2'h2
		|| mode_q.control_mode == 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Function selectors.

	logic [7:0] dflt [7];
	logic [55:0] func_all;
	logic [7:0] rsvd_func;

	always_comb begin
		dflt[0] = alt_ctrl ? `ITD_ALT_F1 : `ITD_RST_F1;
		dflt[1] = mode_q.tension_nonzero ? `ITD_ALT_F2 : `ITD_RST_F2;
		dflt[2] = alt_ctrl ? `ITD_ALT_F3 : `ITD_RST_F3;
		dflt[3] = alt_ctrl ? `ITD_ALT_F4 : `ITD_RST_F4;
		dflt[4] = alt_ctrl ? `ITD_ALT_F5 : `ITD_RST_F5;
		dflt[5] = alt_ctrl ? `ITD_ALT_F6 : `ITD_RST_F6;
		dflt[6] = `ITD_RST_FP;
	end

	assign rsvd_func = 8'h00;

	for (genvar g = 0; g < 7; g++) begin : g_func
		itd_func_reg u_func (
			.clk_in(clk_in),
			.reset_in(reset_in),
			.default_in(dflt[g]),
			.write_in(wr_in && addr_in == 4'(g)),
			.data_in(wdata_in),
			.func_out(func_all[g*8 +: 8])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Decode of terminal levels.

	logic [6:0] level;
	itd_cmd_s cmd_now;
	itd_cmd_s cmd_q;

	// A shorted terminal reads low at the pin and counts as asserted.
	assign level = ~{fast_pulse_n_in, switch_in_n_in};

	itd_decode u_dec (
		.level_in(level),
		.func_in(func_all),
		.mode_in(mode_q),
		.cmd_out(cmd_now)
	);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cmd_q <= '0;
		end else begin
			cmd_q <= cmd_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault latch: raised by an external fault, cleared by a reset command.

	logic fault_q;
	logic next_fault;
	logic clr_req;

	assign clr_req = cmd_now.fault_clear || keypad_reset_in;

	always_comb begin
		next_fault = fault_q;
		if (cmd_now.ext_fault) begin
			next_fault = 1'b1;
		end else if (clr_req) begin
			next_fault = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= next_fault;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event status, mask and interrupt.

	logic [3:0] status_q;
	logic [3:0] next_status;
	logic [3:0] mask_q;
	logic [3:0] next_mask;
	logic [3:0] events;
	logic irq_q;

	// Bit 0 fault raised, 1 coast stop, 2 emergency stop, 3 fault cleared.
	assign events = {fault_q && !next_fault,
		cmd_now.emergency_stop && !cmd_q.emergency_stop,
		cmd_now.coast_stop && !cmd_q.coast_stop,
		next_fault && !fault_q};

	always_comb begin
		next_status = status_q;
		next_mask = mask_q;
		if (wr_in && addr_in == `ITD_ADDR_STATUS) begin
			next_status = status_q & ~wdata_in[3:0];
		end
		if (wr_in && addr_in == `ITD_ADDR_MASK) begin
			next_mask = wdata_in[3:0];
		end
		// A new event beats a clear in the same cycle.
		next_status = next_status | events;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			status_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			status_q <= next_status;
			mask_q <= next_mask;
			irq_q <= |(next_status & next_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port.

	logic [7:0] rdata_q;
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = 8'h00;
		if (rd_in) begin
			if (addr_in <= `ITD_ADDR_FUNC7) begin
				if (addr_in == `ITD_ADDR_FUNC7) begin
					next_rdata = rsvd_func;
				end else begin
					next_rdata = func_all[addr_in[2:0]*8 +: 8];
				end
			end else begin
				unique case (addr_in)
					`ITD_ADDR_MODE: next_rdata = {1'b0, mode_q};
					`ITD_ADDR_STATUS: next_rdata = {4'h0, status_q};
					`ITD_ADDR_MASK: next_rdata = {4'h0, mask_q};
					`ITD_ADDR_CMD: next_rdata = {cmd_q.speed_segment,
						fault_q, cmd_q.emergency_stop,
						cmd_q.coast_stop, cmd_q.forward_run};
					`ITD_ADDR_PINS: next_rdata = {1'b0, level};
					default: next_rdata = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	logic [7:0] code_q;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			code_q <= 8'h00;
		end else begin
			code_q <= next_fault ? `ITD_FAULT_CODE : 8'h00;
		end
	end

	assign rdata_out = rdata_q;
	assign cmd_out = cmd_q;
	assign fault_active_out = fault_q;
	assign fault_code_out = code_q;
	assign irq_out = irq_q;
endmodule

// ---- tb.sv ----
/*
 Self-checking bench of the input terminal function decoder.
 Assumes the contact model drives the terminals and registers use the port.
*/
`timescale 1ns/1ps
module tb import itd_pkg::*;;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic keypad_reset_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [6:0] closed = 7'h00;
	logic [5:0] switch_in_n_in;
	logic fast_pulse_n_in;
	logic [7:0] rdata_out;
	itd_cmd_s cmd_out;
	logic fault_active_out;
	logic [7:0] fault_code_out;
	logic irq_out;
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [7:0] dflt [8] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h08, 8'h00,
		8'h2D, 8'h00};
	logic [7:0] alt [7] = '{8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h2D};
	logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06,
		8'h07, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h10};
	logic [15:0] exps [12] = '{16'h0000, 16'h8000, 16'h4000, 16'h1000,
		16'h0800, 16'h0400, 16'h0200, 16'h0080, 16'h0040, 16'h0020,
		16'h0010, 16'h0002};
	always #2.5 clk_in = ~clk_in;
	itd_contacts sw (.closed_in(closed), .switch_in_n_out(switch_in_n_in),
		.fast_pulse_n_out(fast_pulse_n_in));
	itd_top dut (.clk_in(clk_in), .reset_in(reset_in),
		.switch_in_n_in(switch_in_n_in), .fast_pulse_n_in(fast_pulse_n_in),
		.keypad_reset_in(keypad_reset_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .cmd_out(cmd_out),
		.fault_active_out(fault_active_out), .fault_code_out(fault_code_out),
		.irq_out(irq_out));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] x);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 chk("rdata", rdata_out, x);
	endtask
	task automatic pins(input logic [6:0] v);
		@(posedge clk_in);
		closed <= v;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	task automatic wrap_up();
		if (n_fail == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 8; i++) rd(i[3:0], dflt[i]);
		wr(4'h0, 8'h42);
		rd(4'h0, 8'h01);
		wr(4'h7, 8'h55);
		rd(4'h7, 8'h00);
		rd(4'hF, 8'h00);
		wr(4'h8, 8'h0C);
		rd(4'h8, 8'h0C);
		for (int i = 0; i < 12; i++) begin
			wr(4'h0, codes[i]);
			pins(7'h01);
			chk("cmd", cmd_out, exps[i]);
			pins(7'h00);
		end
		wr(4'h0, 8'h01);
		pins(7'h01);
		chk("forward", cmd_out, 16'h8000);
		wr(4'h8, 8'h08);
		pins(7'h01);
		chk("forward_off", cmd_out, 16'h0000);
		wr(4'h0, 8'h0C);
		pins(7'h01);
		chk("up", cmd_out, 16'h0040);
		wr(4'h8, 8'h04);
		pins(7'h01);
		chk("up_off", cmd_out, 16'h0000);
		wr(4'h0, 8'h0F);
		wr(4'h1, 8'h10);
		wr(4'h2, 8'h11);
		wr(4'h3, 8'h12);
		wr(4'h5, 8'h0F);
		for (int v = 0; v < 16; v++) begin
			pins(v[6:0]);
			chk("seg", cmd_out.speed_segment, v[3:0]);
		end
		pins(7'h20);
		chk("seg_or", cmd_out.speed_segment, 4'h1);
		pins(7'h21);
		chk("seg_or2", cmd_out.speed_segment, 4'h1);
		rd(4'hC, 8'h21);
		rd(4'hB, 8'h10);
		wr(4'hA, 8'h01);
		pins(7'h10);
		chk("fault", {fault_active_out, irq_out, fault_code_out}, 10'h313);
		pins(7'h00);
		chk("latch", fault_active_out, 1'b1);
		@(posedge clk_in);
		keypad_reset_in <= 1'b1;
		@(posedge clk_in);
		keypad_reset_in <= 1'b0;
		pins(7'h00);
		chk("key_clr", {fault_active_out, irq_out}, 2'b01);
		rd(4'h9, 8'h0F);
		wr(4'h9, 8'hFF);
		pins(7'h00);
		chk("irq_clr", irq_out, 1'b0);
		rd(4'h9, 8'h00);
		wr(4'h5, 8'h09);
		pins(7'h00);
		chk("nc_fault", fault_active_out, 1'b1);
		wr(4'h3, 8'h07);
		pins(7'h28);
		chk("term_clr", fault_active_out, 1'b0);
		wr(4'h8, 8'h40);
		wr(4'h0, 8'h03);
		pins(7'h20);
		chk("stop3", cmd_out.three_wire_stop, 1'b1);
		pins(7'h21);
		chk("run3", cmd_out.three_wire_stop, 1'b0);
		wr(4'h8, 8'h12);
		@(posedge clk_in);
		reset_in <= 1'b1;
		@(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 7; i++) rd(i[3:0], alt[i]);
		wrap_up();
	end
endmodule
